// ### bench/sts_periph_model.sv
// Serial peripheral on the far side: captures 16-bit words MSB first.
// Assumes sclk idles low, data sampled on its rising edge.
`timescale 1ns/1ns
`default_nettype none
module sts_periph_model #(
    parameter logic [15:0] RESP0 = 16'hc3a1
) (
    input wire logic sclk, // Serial clock from the master
    input wire logic mosi, // Data from the master
    input wire logic [3:0] cs, // Chip-select code, all ones idle
    output logic miso, // Data to the master
    output logic [15:0] got, // Last word received
    output int frames // Words completed
);
    logic [15:0] sh;
    logic [15:0] rx;
    int nb;
    initial begin
        miso = 1'b0;
        got = 16'h0000;
        frames = 0;
        nb = 0;
        rx = 16'h0000;
    end
    // Deselected line shows the inverse of its last level
    always @(cs) begin
        if (cs == 4'hf)
            miso = ~miso;
        else if (nb == 0) begin
            sh = RESP0 + 16'(frames);
            miso = sh[15];
        end
    end
    always @(posedge sclk) begin
        if (cs != 4'hf) begin
            rx = {rx[14:0], mosi};
            nb = nb + 1;
            if (nb == 16) begin
                got = rx;
                nb = 0;
                frames = frames + 1;
            end
        end
    end
    // Each word answers with the next response value
    always @(negedge sclk) begin
        if (nb == 0)
            sh = RESP0 + 16'(frames);
        else
            sh = sh << 1;
        miso = sh[15];
    end
endmodule
`default_nettype wire

// ### bench/sts_top_monitor.sv
// Checker for the register port, interrupt masks and enable status.
// Assumes it is bound to sts_top and sees only that module's ports.
`timescale 1ns/1ns
`default_nettype none
module sts_top_monitor (
    input wire logic clk_sys, // System clock
    input wire logic rst, // Async reset, high
    input wire logic [7:0] addr, // Register address
    input wire logic [31:0] wdata, // Write data
    input wire logic wr, // Write strobe
    input wire logic rd, // Read strobe
    input wire logic [31:0] rdata_q, // Read data
    input wire logic miso, // Serial data in
    input wire logic ss_n, // Slave-select in, low active
    input wire logic sclk_q, // Serial clock out
    input wire logic mosi_q, // Serial data out
    input wire logic [3:0] chip_select_out_q, // Chip selects
    input wire logic irq_q // Interrupt
);
    logic en_m;
    logic [9:0] mask_m;
    // Shadow of the enable and mask state, built from bus writes only
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            en_m <= 1'b0;
            mask_m <= 10'h000;
        end else if (wr) begin
            if (addr == sts_pkg::OFF_CTRL && (wdata[0] || wdata[1]))
                en_m <= !wdata[1];
            if (addr == sts_pkg::OFF_IEN)
                mask_m <= mask_m | wdata[9:0];
            if (addr == sts_pkg::OFF_IDIS)
                mask_m <= mask_m & ~wdata[9:0];
        end
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    rdata_idle_a: assert property (!rd |=> rdata_q == 32'h0)
        else $error("read data not zero outside a read");
    unmapped_read_a: assert property (rd && addr == 8'h20
        |=> rdata_q == 32'h0)
        else $error("unmapped read not zero");
    stat_rsvd_a: assert property (rd && addr == sts_pkg::OFF_STAT
        |=> (rdata_q & 32'hfffe_fc00) == 32'h0)
        else $error("status reserved bits not zero");
    enable_bit_a: assert property (rd && addr == sts_pkg::OFF_STAT
        |=> rdata_q[16] == $past(en_m))
        else $error("enable status wrong");
    tx_empty_off_a: assert property (rd && addr == sts_pkg::OFF_STAT && !en_m
        |=> !rdata_q[1])
        else $error("transmit empty set while disabled");
    mask_view_a: assert property (rd && addr == sts_pkg::OFF_IMSK
        |=> rdata_q == {22'h0, $past(mask_m)})
        else $error("mask read wrong");
    irq_off_a: assert property (mask_m == 10'h0 |=> !irq_q)
        else $error("interrupt with all masks clear");
    done_clear_a: assert property (wr && addr == sts_pkg::OFF_TXD ##2
        rd && addr == sts_pkg::OFF_STAT |=> !rdata_q[9])
        else $error("transfer done set right after a write");
    cover property (wr && addr == sts_pkg::OFF_TXD);
    cover property ($fell(irq_q));
    cover property (rd && addr == sts_pkg::OFF_STAT ##1 rdata_q[3]);
endmodule
bind sts_top sts_top_monitor sts_top_monitor_inst (.clk_sys, .rst, .addr,
    .wdata, .wr, .rd, .rdata_q, .miso, .ss_n, .sclk_q, .mosi_q,
    .chip_select_out_q, .irq_q);
`default_nettype wire

// ### bench/tb_spi_tx_status_irq_regs.sv
// Testbench for sts_top: register table rows, then link transfers.
// Assumes the peripheral model answers 16'hc3a1 plus the word count.
`timescale 1ns/1ns
`default_nettype none
module tb_spi_tx_status_irq_regs;
    typedef struct packed {
        logic [7:0] wa;
        logic [31:0] wd;
        logic [7:0] ra;
        logic [31:0] m;
        logic [31:0] e;
    } sts_row_t;
    localparam sts_row_t ROWS [17] = '{
        '{8'h24, 32'hffffffff, 8'h10, 32'hfffffccf, 32'h000000c0},
        '{8'h24, 32'hffffffff, 8'h1c, 32'hffffffff, 32'h0},
        '{8'h24, 32'h0, 8'h20, 32'hffffffff, 32'h0},
        '{8'h14, 32'h305, 8'h1c, 32'hffffffff, 32'h305},
        '{8'h14, 32'hf0, 8'h1c, 32'hffffffff, 32'h3f5},
        '{8'h18, 32'h101, 8'h1c, 32'hffffffff, 32'h2f4},
        '{8'h14, 32'hffffffff, 8'h1c, 32'hffffffff, 32'h3ff},
        '{8'h18, 32'hffffffff, 8'h1c, 32'hffffffff, 32'h0},
        '{8'h40, 32'h3, 8'h10, 32'h50, 32'h0},
        '{8'h40, 32'h0, 8'h10, 32'h50, 32'h50},
        '{8'h44, 32'h2, 8'h10, 32'h50, 32'h0},
        '{8'h44, 32'h0, 8'h10, 32'h40, 32'h40},
        '{8'h48, 32'h1, 8'h10, 32'ha0, 32'h0},
        '{8'h48, 32'h0, 8'h10, 32'ha0, 32'ha0},
        '{8'h4c, 32'h4, 8'h10, 32'ha0, 32'h0},
        '{8'h4c, 32'h0, 8'h10, 32'h80, 32'h80},
        '{8'h00, 32'h1, 8'h10, 32'h10002, 32'h10002}};
    logic clk_sys, rst, wr, rd, miso, ss_n, sclk_q, mosi_q, irq_q;
    logic [7:0] addr;
    logic [31:0] wdata, rdata_q;
    logic [3:0] chip_select_out_q;
    logic [15:0] got;
    int frames;
    int fail_count = 0;
    int compares = 0;
    int cyc = 0;
    sts_top sts_top_inst (.clk_sys, .rst, .addr, .wdata, .wr, .rd,
        .rdata_q, .miso, .ss_n, .sclk_q, .mosi_q, .chip_select_out_q,
        .irq_q);
    sts_periph_model #(.RESP0(16'hc3a1)) sts_periph_model_inst (
        .sclk(sclk_q), .mosi(mosi_q), .cs(chip_select_out_q),
        .miso(miso), .got(got), .frames(frames));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk_sys);
        wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] m,
                          input logic [31:0] e);
        @(posedge clk_sys);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk_sys);
        rd <= 1'b0;
        #1 chk(rdata_q & m, e);
    endtask
    task automatic wait_cs(input logic idle);
        int k;
        #1;
        for (k = 0; k < 600 && (chip_select_out_q == 4'hf) !== idle; k++)
            #40;
        chk(32'(k < 600), 32'h1);
    endtask
    task automatic wait_frames(input int n);
        int k;
        #1;
        for (k = 0; k < 800 && frames < n; k++)
            #40;
        chk(32'(frames), 32'(n));
    endtask
    task automatic stop_test();
        $display("Checks %0d, mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 8000) begin
            fail_count++;
            stop_test();
        end
    end
    initial begin
        rst = 1'b1;
        wr = 1'b0;
        rd = 1'b0;
        ss_n = 1'b1;
        addr = 8'h00;
        wdata = 32'h0;
        repeat (8) @(posedge clk_sys);
        rst <= 1'b0;
        foreach (ROWS[i]) begin
            wr_reg(ROWS[i].wa, ROWS[i].wd);
            rd_chk(ROWS[i].ra, ROWS[i].m, ROWS[i].e);
        end
        wr_reg(8'h14, 32'h40);
        repeat (2) @(posedge clk_sys);
        #1 chk(32'(irq_q), 32'h1);
        wr_reg(8'h18, 32'h40);
        repeat (2) @(posedge clk_sys);
        #1 chk(32'(irq_q), 32'h0);
        // Fixed select: the per-word code must be ignored
        wr_reg(8'h04, 32'h000e0001);
        wr_reg(8'h0c, 32'h0107a55a);
        wait_cs(1'b0);
        chk(32'(chip_select_out_q), 32'he);
        wait_frames(1);
        wait_cs(1'b1);
        chk(32'(got), 32'ha55a);
        rd_chk(8'h10, 32'h1, 32'h1);
        rd_chk(8'h08, 32'hffff, 32'hc3a1);
        rd_chk(8'h10, 32'h1, 32'h0);
        // Variable select, decoder on, select held; counts run down to zero
        wr_reg(8'h04, 32'h00000007);
        wr_reg(8'h30, 32'h8);
        wr_reg(8'h40, 32'h1);
        wr_reg(8'h48, 32'h1);
        wr_reg(8'h0c, 32'h000b1234);
        wait_cs(1'b0);
        chk(32'(chip_select_out_q), 32'hb);
        wait_frames(2);
        repeat (40) @(posedge clk_sys);
        #1 chk(32'(chip_select_out_q), 32'hb);
        rd_chk(8'h10, 32'h30, 32'h30);
        wr_reg(8'h0c, 32'h010b5678);
        rd_chk(8'h10, 32'h200, 32'h0);
        wait_frames(3);
        wait_cs(1'b1);
        chk(32'(got), 32'h5678);
        rd_chk(8'h10, 32'h8, 32'h8);
        rd_chk(8'h10, 32'h8, 32'h0);
        rd_chk(8'h08, 32'hffff, 32'hc3a2);
        repeat (20) @(posedge clk_sys);
        rd_chk(8'h10, 32'h202, 32'h202);
        @(posedge clk_sys);
        ss_n <= 1'b0;
        repeat (4) @(posedge clk_sys);
        ss_n <= 1'b1;
        repeat (6) @(posedge clk_sys);
        rd_chk(8'h10, 32'h104, 32'h104);
        rd_chk(8'h10, 32'h104, 32'h0);
        wr_reg(8'h00, 32'h3);
        rd_chk(8'h10, 32'h10002, 32'h0);
        wr_reg(8'h14, 32'h3ff);
        repeat (2) @(posedge clk_sys);
        #1 chk(32'(irq_q), 32'h1);
        // Reset in mid-run: masks and flags return to their reset state
        @(posedge clk_sys);
        rst <= 1'b1;
        repeat (3) @(posedge clk_sys);
        rst <= 1'b0;
        rd_chk(8'h1c, 32'hffffffff, 32'h0);
        rd_chk(8'h10, 32'h103ff, 32'hc0);
        chk(32'(irq_q), 32'h0);
        chk(32'(chip_select_out_q), 32'hf);
        stop_test();
    end
endmodule
`default_nettype wire

// ### core/sts_link_if.sv
// Interface between the register block and the serializer.
// Assumes both ends run on clk_sys.
`timescale 1ns/1ns
`default_nettype none
interface sts_link_if;
    logic load;          // Pulse: new word handed to the serializer
    logic [15:0] word;   // Word to shift out
    logic [3:0] cs;      // Chip-select code for this word
    logic busy;          // Serializer shifting
    logic done;          // Pulse: word finished
    logic [15:0] rx;     // Word received at done
    modport ctl (output load, word, cs, input busy, done, rx);
    modport ser (input load, word, cs, output busy, done, rx);
endinterface
`default_nettype wire

// ### core/sts_pkg.sv
// Package for the serial-interface transmit, status and interrupt block.
// Assumes a 32-bit register port on clk_sys; sts_top, sts_ser and the monitor use it by scope.
package sts_pkg;
    // Register offsets (byte addresses, one aligned word each)
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_MODE = 8'h04;
    localparam logic [7:0] OFF_RXD = 8'h08;
    localparam logic [7:0] OFF_TXD = 8'h0c;
    localparam logic [7:0] OFF_STAT = 8'h10;
    localparam logic [7:0] OFF_IEN = 8'h14;
    localparam logic [7:0] OFF_IDIS = 8'h18;
    localparam logic [7:0] OFF_IMSK = 8'h1c;
    localparam logic [7:0] OFF_CSEL = 8'h30;
    localparam logic [7:0] OFF_RCNT = 8'h40;
    localparam logic [7:0] OFF_RNCNT = 8'h44;
    localparam logic [7:0] OFF_TCNT = 8'h48;
    localparam logic [7:0] OFF_TNCNT = 8'h4c;
    // Control register bits
    localparam int CTRL_EN = 0;
    localparam int CTRL_DIS = 1;
    // Mode register bits
    localparam int MODE_MSTR = 0;
    localparam int MODE_SRC = 1;
    localparam int MODE_DEC = 2;
    localparam int MODE_CS_LO = 16;
    localparam int MODE_DLY_LO = 24;
    // Chip-select config bits
    localparam int CSEL_KEEP = 3;
    // Transmit word fields
    localparam int TXD_CS_LO = 16;
    localparam int TXD_LAST = 24;
    // Status bit positions
    localparam int ST_RXF = 0;
    localparam int ST_TXE = 1;
    localparam int ST_MODE_FAULT_FLAG = 2;
    localparam int ST_OVR = 3;
    localparam int ST_RXEND = 4;
    localparam int ST_TXEND = 5;
    localparam int ST_RXZ = 6;
    localparam int ST_TXZ = 7;
    localparam int ST_SSR = 8;
    localparam int ST_DONE = 9;
    localparam int ST_EN = 16;
    localparam logic [9:0] IRQ_BITS = 10'h3ff;
    // Link timing
    localparam int WORD_BITS = 16;
    localparam logic [3:0] CS_IDLE = 4'hf;
    localparam logic [7:0] MIN_GAP = 8'h06;
    localparam logic [15:0] CNT_W = 16'h0000;
    localparam logic [4:0] BITCNT_RST = 5'h00;
endpackage

// ### core/sts_ser.sv
// Serializer: shifts a 16-bit word on a divided clock, master side.
// Assumes the controller only loads while busy is low.
`timescale 1ns/1ns
`default_nettype none
module sts_ser (
    input wire logic clk_sys,   // System clock
    input wire logic rst,       // Async reset, high
    input wire logic miso_s,    // Synchronised serial input
    sts_link_if.ser lk,         // Controller side
    output logic sclk_q,        // Serial clock out
    output logic mosi_q         // Serial data out
);
    typedef struct packed {
        logic busy;
        logic done;
        logic [4:0] bits;
        logic [2:0] div;
        logic sck;
        logic [15:0] sh;
        logic [15:0] rx;
    } sts_ser_t;
    sts_ser_t s_q, s_d;
    always_comb begin
        s_d = s_q;
        s_d.done = 1'b0;
        if (!s_q.busy && lk.load) begin
            s_d.busy = 1'b1;
            s_d.sh = lk.word;
            s_d.bits = sts_pkg::BITCNT_RST;
            s_d.div = 3'h0;
        end else if (s_q.busy) begin
            s_d.div = s_q.div + 3'h1;
            if (s_q.div == 3'h7) begin
                s_d.sck = !s_q.sck;
                if (s_q.sck) begin
                    s_d.sh = {s_q.sh[14:0], miso_s};
                    s_d.bits = s_q.bits + 5'h1;
                    if (s_q.bits == 5'(sts_pkg::WORD_BITS - 1)) begin
                        s_d.busy = 1'b0;
                        s_d.done = 1'b1;
                        s_d.rx = {s_q.sh[14:0], miso_s};
                    end
                end
            end
        end
    end
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
    assign lk.busy = s_q.busy;
    assign lk.done = s_q.done;
    assign lk.rx = s_q.rx;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            sclk_q <= 1'b0;
            mosi_q <= 1'b0;
        end else begin
            sclk_q <= s_d.sck;
            mosi_q <= s_d.sh[15];
        end
    end
endmodule
`default_nettype wire

// ### core/sts_sync.sv
// Two-flop synchroniser for one level from outside clk_sys.
// Assumes the output is the only thing read downstream.
`timescale 1ns/1ns
`default_nettype none
module sts_sync (
    input wire logic clk_sys,  // System clock
    input wire logic rst,      // Async reset, high
    input wire logic d,        // Asynchronous level
    output logic q             // Synchronised level
);
    logic [1:0] ff_q;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ff_q <= 2'h0;
        end else begin
            ff_q <= {ff_q[0], d};
        end
    end
    assign q = ff_q[1];
endmodule
`default_nettype wire

// ### core/sts_top.sv
// Transmit data, status and interrupt registers with a simple serializer.
// Assumes a one-cycle strobe register port on clk_sys, reads answer next
// cycle; serial inputs are asynchronous and synchronised here.
//
// Added by the designer: the strobed register port and the address map.
`timescale 1ns/1ns
`default_nettype none
module sts_top (
    input wire logic clk_sys,          // System clock, 25 MHz
    input wire logic rst,              // Async reset, high
    input wire logic [7:0] addr,       // Register byte address
    input wire logic [31:0] wdata,     // Write data
    input wire logic wr,               // Write strobe
    input wire logic rd,               // Read strobe
    output logic [31:0] rdata_q,       // Read data, cycle after rd
    input wire logic miso,             // Serial data in (pin)
    input wire logic ss_n,             // Slave-select input pin, low active
    output logic sclk_q,               // Serial clock out
    output logic mosi_q,               // Serial data out
    output logic [3:0] chip_select_out_q, // Chip selects, low active
    output logic irq_q                 // Interrupt, high
);
    typedef struct packed {
        logic en;
        logic [31:0] mode;
        logic keep;
        logic [9:0] imask;
        logic rxf, txe, mode_fault_flag, ovr, rxend, txend, ssr, done;
        logic [15:0] rxd;
        logic [15:0] txw;
        logic [3:0] txcs;
        logic txlast;
        logic pend;
        logic last_act;
        logic [3:0] cs;
        logic [7:0] gap;
        logic ss_prev;
        logic [15:0] rcnt, rncnt, tcnt, tncnt;
    } sts_top_t;
    sts_top_t s_q, s_d;
    logic miso_s, ss_s, ss_act, load;
    logic [3:0] cs_sel;
    logic [7:0] gap_ld;
    logic [31:0] rd_d;
    logic [9:0] flags;
    sts_link_if lk ();

    sts_sync u_sm (.clk_sys(clk_sys), .rst(rst), .d(miso), .q(miso_s));
    // Inverted so the reset value matches the idle pin: no false edge
    sts_sync u_ss (.clk_sys(clk_sys), .rst(rst), .d(!ss_n), .q(ss_act));
    assign ss_s = !ss_act;
    sts_ser u_ser (
        .clk_sys(clk_sys),
        .rst(rst),
        .miso_s(miso_s),
        .lk(lk),
        .sclk_q(sclk_q),
        .mosi_q(mosi_q)
    );

    function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
        hit = (a == o);
    endfunction

    // Select code from mode register or from the word
    always_comb begin
        if (s_q.mode[sts_pkg::MODE_SRC]) begin
            cs_sel = s_q.txcs;
        end else begin
            cs_sel = s_q.mode[sts_pkg::MODE_CS_LO +: 4];
        end
    end

    // No load in the done cycle or while another select must drop first
    assign load = s_q.en && s_q.pend && !lk.busy && !lk.done &&
        s_q.gap == 8'h00 &&
        (s_q.cs == sts_pkg::CS_IDLE || s_q.cs == cs_sel);
    assign gap_ld = s_q.mode[sts_pkg::MODE_DLY_LO +: 8] > sts_pkg::MIN_GAP
        ? s_q.mode[sts_pkg::MODE_DLY_LO +: 8] : sts_pkg::MIN_GAP;
    assign lk.load = load;
    assign lk.word = s_q.txw;
    assign lk.cs = cs_sel;
    assign flags = {s_q.done, s_q.ssr, s_q.tcnt == 16'h0 && s_q.tncnt == 16'h0,
        s_q.rcnt == 16'h0 && s_q.rncnt == 16'h0, s_q.txend, s_q.rxend,
        s_q.ovr, s_q.mode_fault_flag, s_q.txe, s_q.rxf};

    always_comb begin
        s_d = s_q;
        s_d.ss_prev = ss_s;
        if (s_q.gap != 8'h00) begin
            s_d.gap = s_q.gap - 8'h01;
        end
        // Serial side events
        if (load) begin
            s_d.pend = 1'b0;
            s_d.txe = 1'b1;
            s_d.last_act = s_q.txlast;
            s_d.cs = cs_sel;
        end
        if (lk.done) begin
            if (s_q.rxf) begin
                s_d.ovr = 1'b1;
            end else begin
                s_d.rxd = lk.rx;
                s_d.rxf = 1'b1;
            end
            if (!s_q.keep || s_q.last_act) begin
                s_d.cs = sts_pkg::CS_IDLE;
                s_d.last_act = 1'b0;
            end
            s_d.gap = gap_ld;
        end
        // A new select other than the held one releases it first
        if (s_q.pend && !lk.busy && s_q.cs != sts_pkg::CS_IDLE &&
                s_q.cs != cs_sel) begin
            s_d.cs = sts_pkg::CS_IDLE;
            s_d.gap = gap_ld;
        end
        if (!s_q.pend && !lk.busy && s_q.gap == 8'h00 && s_q.en) begin
            s_d.done = 1'b1;
        end
        // Mode fault: select pulled low while we drive as master
        if (!ss_s && s_q.en && s_q.mode[sts_pkg::MODE_MSTR]) begin
            s_d.mode_fault_flag = 1'b1;
        end
        // Register reads clear flags; hardware sets win on same cycle
        if (rd && hit(addr, sts_pkg::OFF_RXD) && !(lk.done && !s_q.rxf)) begin
            s_d.rxf = 1'b0;
        end
        if (rd && hit(addr, sts_pkg::OFF_STAT)) begin
            s_d.mode_fault_flag = !ss_s && s_q.en && s_q.mode[sts_pkg::MODE_MSTR];
            s_d.ovr = lk.done && s_q.rxf;
            s_d.ssr = ss_s && !s_q.ss_prev;
        end else if (ss_s && !s_q.ss_prev) begin
            s_d.ssr = 1'b1;
        end
        if (wr) begin
            unique case (addr)
                sts_pkg::OFF_CTRL: begin
                    if (wdata[sts_pkg::CTRL_DIS]) begin
                        s_d.en = 1'b0;
                    end else if (wdata[sts_pkg::CTRL_EN]) begin
                        s_d.en = 1'b1;
                        s_d.txe = 1'b1;
                    end
                end
                sts_pkg::OFF_MODE: s_d.mode = wdata;
                sts_pkg::OFF_CSEL: s_d.keep = wdata[sts_pkg::CSEL_KEEP];
                sts_pkg::OFF_TXD: begin
                    s_d.txw = wdata[15:0];
                    s_d.txcs = wdata[sts_pkg::TXD_CS_LO +: 4];
                    s_d.txlast = wdata[sts_pkg::TXD_LAST];
                    s_d.pend = 1'b1;
                    s_d.txe = 1'b0;
                    s_d.done = 1'b0;
                end
                sts_pkg::OFF_IEN: s_d.imask = s_q.imask | wdata[9:0];
                sts_pkg::OFF_IDIS: s_d.imask = s_q.imask & ~wdata[9:0];
                sts_pkg::OFF_RCNT: begin
                    s_d.rcnt = wdata[15:0];
                    s_d.rxend = wdata[15:0] == 16'h0;
                end
                sts_pkg::OFF_RNCNT: begin
                    s_d.rncnt = wdata[15:0];
                    s_d.rxend = 1'b0;
                end
                sts_pkg::OFF_TCNT: begin
                    s_d.tcnt = wdata[15:0];
                    s_d.txend = wdata[15:0] == 16'h0;
                end
                sts_pkg::OFF_TNCNT: begin
                    s_d.tncnt = wdata[15:0];
                    s_d.txend = 1'b0;
                end
                default: ;
            endcase
        end
        // Transmit counter steps down per load, sets its flag at zero
        if (load && s_q.tcnt != 16'h0 &&
                !(wr && hit(addr, sts_pkg::OFF_TCNT))) begin
            s_d.tcnt = s_q.tcnt - 16'h1;
            if (s_q.tcnt == 16'h1) begin
                s_d.txend = 1'b1;
            end
        end
        if (lk.done && !s_q.rxf && s_q.rcnt != 16'h0 &&
                !(wr && hit(addr, sts_pkg::OFF_RCNT))) begin
            s_d.rcnt = s_q.rcnt - 16'h1;
            if (s_q.rcnt == 16'h1) begin
                s_d.rxend = 1'b1;
            end
        end
        if (!s_d.en) begin
            s_d.txe = 1'b0;
        end
    end

    // Read mux; unmapped addresses and reserved positions read zero, except in the mode register, which reads back all 32 bits as written
    always_comb begin
        rd_d = 32'h0000_0000;
        unique case (addr)
            sts_pkg::OFF_MODE: rd_d = s_q.mode;
            sts_pkg::OFF_RXD: rd_d = {16'h0000, s_q.rxd};
            sts_pkg::OFF_STAT: rd_d = {15'h0000, s_q.en, 6'h00, flags};
            sts_pkg::OFF_IMSK: rd_d = {22'h000000, s_q.imask};
            sts_pkg::OFF_CSEL: rd_d = {28'h0000000, s_q.keep, 3'h0};
            sts_pkg::OFF_RCNT: rd_d = {16'h0000, s_q.rcnt};
            sts_pkg::OFF_RNCNT: rd_d = {16'h0000, s_q.rncnt};
            sts_pkg::OFF_TCNT: rd_d = {16'h0000, s_q.tcnt};
            sts_pkg::OFF_TNCNT: rd_d = {16'h0000, s_q.tncnt};
            default: rd_d = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            s_q <= '0;
            s_q.cs <= sts_pkg::CS_IDLE;
            s_q.ss_prev <= 1'b1;
            rdata_q <= 32'h0000_0000;
            chip_select_out_q <= sts_pkg::CS_IDLE;
            irq_q <= 1'b0;
        end else begin
            s_q <= s_d;
            rdata_q <= rd ? rd_d : 32'h0000_0000;
            chip_select_out_q <= s_d.cs;
            irq_q <= |(flags & s_q.imask & sts_pkg::IRQ_BITS);
        end
    end
endmodule
`default_nettype wire
